//--- core/reset_strap_sampler.sv
// strap sampler: captures boot straps at power good and releases pins
`timescale 1ns/100ps
`include "strap_sampler_regs.svh"

// Summary of operation
// - straps are inputs during system reset
// - both audio straps high selects x4
// - otherwise channels 0-3 are x1
// - channel 4 always x1
// - lane reverse strap low reverses graphics
// - video lanes keep normal order
// - display B data high enables port B
// - display C data high enables port C
// - after reset drive four grants low-active
module reset_strap_sampler #(
  parameter int ADDR_W = 4,
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_good,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  input wire logic audio_frame_sync_strap_i,
  output logic audio_frame_sync_strap_o,
  output logic audio_frame_sync_strap_oe,
  input wire logic audio_serial_out_strap_i,
  output logic audio_serial_out_strap_o,
  output logic audio_serial_out_strap_oe,
  input wire logic card_slot_reset_n_i,
  output logic card_slot_reset_n_o,
  output logic card_slot_reset_n_oe,
  input wire logic beeper_out_i,
  output logic beeper_out_o,
  output logic beeper_out_oe,
  input wire logic graphics_lane_reverse_n,
  input wire logic display_b_ctrl_data_strap_i,
  output logic display_b_ctrl_data_strap_o,
  output logic display_b_ctrl_data_strap_oe,
  input wire logic display_c_ctrl_data_strap_i,
  output logic display_c_ctrl_data_strap_o,
  output logic display_c_ctrl_data_strap_oe,
  input wire logic bus_grant0_n_i,
  output logic bus_grant0_n_o,
  output logic bus_grant0_n_oe,
  input wire logic bus_grant1_n_i,
  output logic bus_grant1_n_o,
  output logic bus_grant1_n_oe,
  input wire logic bus_grant2_n_i,
  output logic bus_grant2_n_o,
  output logic bus_grant2_n_oe,
  input wire logic bus_grant3_n_i,
  output logic bus_grant3_n_o,
  output logic bus_grant3_n_oe,
  input wire logic func_frame_sync,
  input wire logic func_serial_out,
  input wire logic func_card_reset_n,
  input wire logic func_beeper,
  input wire logic disp_b_pull_low,
  input wire logic disp_c_pull_low,
  output logic disp_b_level,
  output logic disp_c_level,
  output strap_sampler_pkg::strap_cfg_t cfg,
  output logic cfg_valid,
  output logic pins_functional
);

  // refuse shapes the register map cannot hold
  if (ADDR_W < 2 || ADDR_W > 16)
  begin : g_addr_chk
    $error("ADDR_W must be 2 to 16");
  end
  if (CNT_W < 1 || CNT_W > 16)
  begin : g_cnt_chk
    $error("CNT_W must be 1 to 16");
  end

  // sequencer state
  strap_sampler_pkg::phase_t phase;
  strap_sampler_pkg::phase_t next_phase;
  logic pg_q; // power good one cycle late
  logic next_pg_q;
  logic sample; // rising edge of power good
  logic valid; // a capture has happened
  logic next_valid;
  logic [CNT_W-1:0] cap_count; // captures since chip reset
  logic [CNT_W-1:0] next_cap_count;

  // captured strap meanings
  logic fs_sel; // frame sync strap was high
  logic so_sel; // serial out strap was high
  logic rev_sel; // lane reverse strap was low
  logic b_sel; // display b strap was high
  logic c_sel; // display c strap was high

  // register state
  logic [3:0] grant; // software grant mask, 1 = granted
  logic [3:0] next_grant;
  logic [31:0] next_rdata;

  // live pin levels, for software inspection except grant 0 and 1
  logic fs_lvl;
  logic so_lvl;
  logic gnt_lvl0;
  logic gnt_lvl1;
  logic b_lvl;
  logic c_lvl;
  logic unused_lvl; // card, beeper, grant 2 and 3 levels
  logic lvl_card;
  logic lvl_beep;
  logic lvl_gnt2;
  logic lvl_gnt3;

  // power good rises: the one moment straps count
  assign sample = power_good & ~pg_q;

  // sequencer next state
  always_comb
  begin
    next_phase = phase;
    next_pg_q = power_good;
    next_valid = valid;
    next_cap_count = cap_count;
    case (phase)
      strap_sampler_pkg::ST_HOLD:
      begin
        // pins stay inputs until the edge
        if (sample)
        begin
          next_phase = strap_sampler_pkg::ST_CAPTURE;
          next_valid = 1'b1;
          // saturate rather than wrap
          if (cap_count != '1)
            next_cap_count = cap_count + 1'b1;
        end
      end
      strap_sampler_pkg::ST_CAPTURE:
      begin
        // one extra input cycle before pins turn
        if (power_good)
          next_phase = strap_sampler_pkg::ST_RUN;
        else
          next_phase = strap_sampler_pkg::ST_HOLD;
      end
      strap_sampler_pkg::ST_RUN:
      begin
        // power good dropping is a new system reset
        if (!power_good)
          next_phase = strap_sampler_pkg::ST_HOLD;
      end
      default:
      begin
        next_phase = strap_sampler_pkg::ST_HOLD;
      end
    endcase
  end

  // sequencer registers; pg_q clears so a board already
  // powered at chip reset still gets its straps read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phase <= strap_sampler_pkg::ST_HOLD;
      pg_q <= 1'b0;
      valid <= 1'b0;
      cap_count <= '0;
    end
    else
    begin
      phase <= next_phase;
      pg_q <= next_pg_q;
      valid <= next_valid;
      cap_count <= next_cap_count;
    end
  end

  // pins take their function only in run
  assign pins_functional = (phase == strap_sampler_pkg::ST_RUN);
  assign cfg_valid = valid;

  // strap capture, one latch per strap
  strap_latch #(.DEFAULT(`STRAP_DFLT_AUDIO), .ACTIVE_LOW(1'b0)) u_fs (
    .clk(clk),
    .rst(rst),
    .load(sample),
    .pin_i(audio_frame_sync_strap_i),
    .value(fs_sel)
  );
  strap_latch #(.DEFAULT(`STRAP_DFLT_AUDIO), .ACTIVE_LOW(1'b0)) u_so (
    .clk(clk),
    .rst(rst),
    .load(sample),
    .pin_i(audio_serial_out_strap_i),
    .value(so_sel)
  );
  // active low: low on the pin means reverse
  strap_latch #(.DEFAULT(`STRAP_DFLT_LANE_REV), .ACTIVE_LOW(1'b1)) u_rev (
    .clk(clk),
    .rst(rst),
    .load(sample),
    .pin_i(graphics_lane_reverse_n),
    .value(rev_sel)
  );
  strap_latch #(.DEFAULT(`STRAP_DFLT_DISP), .ACTIVE_LOW(1'b0)) u_b (
    .clk(clk),
    .rst(rst),
    .load(sample),
    .pin_i(display_b_ctrl_data_strap_i),
    .value(b_sel)
  );
  strap_latch #(.DEFAULT(`STRAP_DFLT_DISP), .ACTIVE_LOW(1'b0)) u_c (
    .clk(clk),
    .rst(rst),
    .load(sample),
    .pin_i(display_c_ctrl_data_strap_i),
    .value(c_sel)
  );

  // configuration from the held straps
  always_comb
  begin
    cfg.ch03_width = strap_sampler_pkg::WIDTH_X1;
    if (fs_sel && so_sel)
      cfg.ch03_width = strap_sampler_pkg::WIDTH_X4;
    cfg.ch4_width = strap_sampler_pkg::WIDTH_X1;
    cfg.gfx_lane_rev = rev_sel;
    // video lanes are left in normal order
    cfg.video_lane_rev = 1'b0;
    cfg.disp_b_en = b_sel;
    cfg.disp_c_en = c_sel;
  end

  // shared pins: inputs in reset, function after; the board
  // is trusted not to load card, beeper and grant pins
  shared_pin #(.OPEN_DRAIN(1'b0)) u_pin_fs (
    .clk(clk),
    .rst(rst),
    .functional(pins_functional),
    .func_level(func_frame_sync),
    .func_drive(1'b1),
    .pin_i(audio_frame_sync_strap_i),
    .pin_o(audio_frame_sync_strap_o),
    .pin_oe(audio_frame_sync_strap_oe),
    .level(fs_lvl)
  );
  shared_pin #(.OPEN_DRAIN(1'b0)) u_pin_so (
    .clk(clk),
    .rst(rst),
    .functional(pins_functional),
    .func_level(func_serial_out),
    .func_drive(1'b1),
    .pin_i(audio_serial_out_strap_i),
    .pin_o(audio_serial_out_strap_o),
    .pin_oe(audio_serial_out_strap_oe),
    .level(so_lvl)
  );
  shared_pin #(.OPEN_DRAIN(1'b0)) u_pin_card (
    .clk(clk),
    .rst(rst),
    .functional(pins_functional),
    .func_level(func_card_reset_n),
    .func_drive(1'b1),
    .pin_i(card_slot_reset_n_i),
    .pin_o(card_slot_reset_n_o),
    .pin_oe(card_slot_reset_n_oe),
    .level(lvl_card)
  );
  shared_pin #(.OPEN_DRAIN(1'b0)) u_pin_beep (
    .clk(clk),
    .rst(rst),
    .functional(pins_functional),
    .func_level(func_beeper),
    .func_drive(1'b1),
    .pin_i(beeper_out_i),
    .pin_o(beeper_out_o),
    .pin_oe(beeper_out_oe),
    .level(lvl_beep)
  );
  // display data lines are open drain
  shared_pin #(.OPEN_DRAIN(1'b1)) u_pin_b (
    .clk(clk),
    .rst(rst),
    .functional(pins_functional),
    .func_level(1'b0),
    .func_drive(disp_b_pull_low),
    .pin_i(display_b_ctrl_data_strap_i),
    .pin_o(display_b_ctrl_data_strap_o),
    .pin_oe(display_b_ctrl_data_strap_oe),
    .level(b_lvl)
  );
  shared_pin #(.OPEN_DRAIN(1'b1)) u_pin_c (
    .clk(clk),
    .rst(rst),
    .functional(pins_functional),
    .func_level(1'b0),
    .func_drive(disp_c_pull_low),
    .pin_i(display_c_ctrl_data_strap_i),
    .pin_o(display_c_ctrl_data_strap_o),
    .pin_oe(display_c_ctrl_data_strap_oe),
    .level(c_lvl)
  );
  // grants: granted bit drives the pin low
  shared_pin #(.OPEN_DRAIN(1'b0)) u_pin_g0 (
    .clk(clk),
    .rst(rst),
    .functional(pins_functional),
    .func_level(~grant[0]),
    .func_drive(1'b1),
    .pin_i(bus_grant0_n_i),
    .pin_o(bus_grant0_n_o),
    .pin_oe(bus_grant0_n_oe),
    .level(gnt_lvl0)
  );
  shared_pin #(.OPEN_DRAIN(1'b0)) u_pin_g1 (
    .clk(clk),
    .rst(rst),
    .functional(pins_functional),
    .func_level(~grant[1]),
    .func_drive(1'b1),
    .pin_i(bus_grant1_n_i),
    .pin_o(bus_grant1_n_o),
    .pin_oe(bus_grant1_n_oe),
    .level(gnt_lvl1)
  );
  shared_pin #(.OPEN_DRAIN(1'b0)) u_pin_g2 (
    .clk(clk),
    .rst(rst),
    .functional(pins_functional),
    .func_level(~grant[2]),
    .func_drive(1'b1),
    .pin_i(bus_grant2_n_i),
    .pin_o(bus_grant2_n_o),
    .pin_oe(bus_grant2_n_oe),
    .level(lvl_gnt2)
  );
  shared_pin #(.OPEN_DRAIN(1'b0)) u_pin_g3 (
    .clk(clk),
    .rst(rst),
    .functional(pins_functional),
    .func_level(~grant[3]),
    .func_drive(1'b1),
    .pin_i(bus_grant3_n_i),
    .pin_o(bus_grant3_n_o),
    .pin_oe(bus_grant3_n_oe),
    .level(lvl_gnt3)
  );

  assign disp_b_level = b_lvl;
  assign disp_c_level = c_lvl;
  // folded levels shown as one live bit
  assign unused_lvl = lvl_card ^ lvl_beep ^ lvl_gnt2 ^ lvl_gnt3;

  // register port next values
  always_comb
  begin
    next_grant = grant;
    next_rdata = '0;
    // only the grant register is writable
    if (reg_we && reg_addr == ADDR_W'(`STRAP_ADDR_GRANT))
      next_grant = reg_wdata[`STRAP_GRANT_HI:`STRAP_GRANT_LO];
    if (reg_re)
    begin
      case (reg_addr)
        ADDR_W'(`STRAP_ADDR_STATUS):
        begin
          next_rdata[`STRAP_BIT_CH03_X4] = cfg.ch03_width;
          next_rdata[`STRAP_BIT_LANE_REV] = cfg.gfx_lane_rev;
          next_rdata[`STRAP_BIT_DISP_B] = cfg.disp_b_en;
          next_rdata[`STRAP_BIT_DISP_C] = cfg.disp_c_en;
          next_rdata[`STRAP_BIT_VALID] = valid;
          next_rdata[`STRAP_BIT_RUN] = pins_functional;
          next_rdata[`STRAP_BIT_LIVE_HI:`STRAP_BIT_LIVE_LO] =
            {unused_lvl, c_lvl, b_lvl, so_lvl, fs_lvl};
        end
        ADDR_W'(`STRAP_ADDR_GRANT):
        begin
          next_rdata[`STRAP_GRANT_HI:`STRAP_GRANT_LO] = grant;
        end
        ADDR_W'(`STRAP_ADDR_COUNT):
        begin
          next_rdata[CNT_W-1:0] = cap_count;
        end
        default:
        begin
          // unmapped reads return zero
          next_rdata = '0;
        end
      endcase
    end
  end

  // register port state; read data lasts one cycle only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      grant <= `STRAP_GRANT_RST;
      reg_rdata <= '0;
    end
    else
    begin
      grant <= next_grant;
      reg_rdata <= next_rdata;
    end
  end

  // grant levels 0 and 1 are not in live status nor on any output
  logic unused_gnt; // kept for lint, not observable
  assign unused_gnt = gnt_lvl0 & gnt_lvl1;

endmodule

//--- inc/strap_sampler_regs.svh
// register offsets, field positions and reset values of the strap sampler
`ifndef STRAP_SAMPLER_REGS_SVH
`define STRAP_SAMPLER_REGS_SVH

// register offsets on the plain register port
`define STRAP_ADDR_STATUS 4'h0
`define STRAP_ADDR_GRANT 4'h1
`define STRAP_ADDR_COUNT 4'h2

// status register field positions
`define STRAP_BIT_CH03_X4 0
`define STRAP_BIT_LANE_REV 1
`define STRAP_BIT_DISP_B 2
`define STRAP_BIT_DISP_C 3
`define STRAP_BIT_VALID 4
`define STRAP_BIT_RUN 5
`define STRAP_BIT_LIVE_LO 8
`define STRAP_BIT_LIVE_HI 12

// grant register field
`define STRAP_GRANT_LO 0
`define STRAP_GRANT_HI 3
`define STRAP_GRANT_RST 4'h0

// strap defaults, in meaning (1 = feature selected)
`define STRAP_DFLT_AUDIO 1'b0
`define STRAP_DFLT_LANE_REV 1'b0
`define STRAP_DFLT_DISP 1'b0

// idle level of a pin while it is an input
`define STRAP_IDLE_LEVEL 1'b0

`endif

//--- inc/strap_sampler_pkg.sv
// types shared by the strap sampler files
package strap_sampler_pkg;

  // width of a serial expansion link
  typedef enum logic {
    WIDTH_X1 = 1'b0,
    WIDTH_X4 = 1'b1
  } link_width_t;

  // sequencer phases around system reset
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN = 2'b10
  } phase_t;

  // configuration taken from the straps
  typedef struct packed {
    link_width_t ch03_width;
    link_width_t ch4_width;
    logic gfx_lane_rev;
    logic video_lane_rev;
    logic disp_b_en;
    logic disp_c_en;
  } strap_cfg_t;

  // drive of one shared pin
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;

endpackage

//--- core/strap_latch.sv
// one strap value, captured on a load pulse and held
`timescale 1ns/100ps
module strap_latch #(
  parameter bit DEFAULT = 1'b0,
  parameter bit ACTIVE_LOW = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic pin_i,
  output logic value
);

  logic next_value; // value after this edge

  // load once per sampling edge, otherwise keep
  always_comb
  begin
    next_value = value;
    if (load)
    begin
      // fold polarity so value always means selected
      next_value = pin_i ^ ACTIVE_LOW;
    end
  end

  // reset to the strap's default meaning
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      value <= DEFAULT;
    else
      value <= next_value;
  end

endmodule

//--- core/shared_pin.sv
// drive control of one pin shared between strap and function
`timescale 1ns/100ps
`include "strap_sampler_regs.svh"
module shared_pin #(
  parameter bit OPEN_DRAIN = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic functional,
  input wire logic func_level,
  input wire logic func_drive,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic level
);

  strap_sampler_pkg::pin_drive_t drive; // registered pin drive
  strap_sampler_pkg::pin_drive_t next_drive;
  logic next_level; // sampled pin level

  // input while straps matter, function otherwise
  always_comb
  begin
    next_drive.o = `STRAP_IDLE_LEVEL;
    next_drive.oe = 1'b0;
    next_level = pin_i;
    if (functional)
    begin
      if (OPEN_DRAIN)
      begin
        // open drain only ever pulls low
        next_drive.o = 1'b0;
        next_drive.oe = func_drive;
      end
      else
      begin
        next_drive.o = func_level;
        next_drive.oe = 1'b1;
      end
    end
  end

  // reset leaves the pin undriven
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      drive <= '0;
      level <= 1'b0;
    end
    else
    begin
      drive <= next_drive;
      level <= next_level;
    end
  end

  assign pin_o = drive.o;
  assign pin_oe = drive.oe;

endmodule

//--- test/strap_board.sv
// board model: strap resistors and loads on the shared pins
`timescale 1ns/100ps
`include "strap_sampler_regs.svh"
module strap_board (
  input wire logic [9:0] pin_o,
  input wire logic [9:0] pin_oe,
  input wire logic [4:0] fit,
  output logic [9:0] pin_i,
  output logic lane_n
);
  // pin order: frame, serial, card, beeper, disp b, disp c, grants 0..3
  // fit: frame, serial, disp b, disp c pull-ups, lane reversal pull-down
  // a released pin falls to its resistor, never to its last driven value
  always_comb
  begin
    pin_i = {10{`STRAP_IDLE_LEVEL}};
    pin_i[0] = fit[0];
    pin_i[1] = fit[1];
    pin_i[4] = fit[2];
    pin_i[5] = fit[3];
    // open-drain display pins can only be pulled low by the device
    for (int k = 0; k < 10; k++)
      if (pin_oe[k])
        pin_i[k] = (k == 4 || k == 5) ? 1'h0 : pin_o[k];
  end
  // lane reversal resistor pulls the input-only strap low
  assign lane_n = !fit[4];
endmodule

//--- test/reset_strap_sampler_chk.sv
// port assertions of the strap sampler
`timescale 1ns/100ps
module reset_strap_sampler_chk #(
  parameter int ADDR_W = 4,
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_good,
  input wire logic audio_frame_sync_strap_i,
  input wire logic audio_serial_out_strap_i,
  input wire logic graphics_lane_reverse_n,
  input wire logic display_b_ctrl_data_strap_i,
  input wire logic display_c_ctrl_data_strap_i,
  input wire logic audio_frame_sync_strap_oe,
  input wire logic audio_serial_out_strap_oe,
  input wire logic card_slot_reset_n_oe,
  input wire logic beeper_out_oe,
  input wire logic display_b_ctrl_data_strap_oe,
  input wire logic display_c_ctrl_data_strap_oe,
  input wire logic bus_grant0_n_oe,
  input wire logic bus_grant1_n_oe,
  input wire logic bus_grant2_n_oe,
  input wire logic bus_grant3_n_oe,
  input wire strap_sampler_pkg::strap_cfg_t cfg,
  input wire logic cfg_valid,
  input wire logic pins_functional
);
  logic pg_q; // power good a cycle back, cleared by reset
  logic cap; // sampling cycle
  logic any_oe; // some pin driven
  // mirror of the edge detector, so a high level at release counts too
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pg_q <= 1'h0;
    else
      pg_q <= power_good;
  end
  assign cap = power_good && !pg_q;
  assign any_oe = |{audio_frame_sync_strap_oe, audio_serial_out_strap_oe,
    card_slot_reset_n_oe, beeper_out_oe, display_b_ctrl_data_strap_oe,
    display_c_ctrl_data_strap_oe, bus_grant0_n_oe, bus_grant1_n_oe,
    bus_grant2_n_oe, bus_grant3_n_oe};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_pins_input: assert property (any_oe |-> $past(pins_functional))
    else $error("pin driven outside run");
  a_run_ends: assert property (!power_good |=> !pins_functional)
    else $error("run kept during system reset");
  a_valid_set: assert property (
    cap ##1 power_good |=> cfg_valid && pins_functional)
    else $error("capture did not lead to run");
  a_x4_select: assert property (
    cap && audio_frame_sync_strap_i && audio_serial_out_strap_i |=>
    cfg.ch03_width == strap_sampler_pkg::WIDTH_X4)
    else $error("x4 not selected");
  a_x1_default: assert property (
    cap && !(audio_frame_sync_strap_i && audio_serial_out_strap_i) |=>
    cfg.ch03_width == strap_sampler_pkg::WIDTH_X1)
    else $error("x1 default lost");
  a_ch4_narrow: assert property (
    cfg.ch4_width == strap_sampler_pkg::WIDTH_X1)
    else $error("channel four not x1");
  a_lane_reverse: assert property (
    cap |=> cfg.gfx_lane_rev == !$past(graphics_lane_reverse_n))
    else $error("lane reversal wrong");
  a_video_order: assert property (!cfg.video_lane_rev)
    else $error("video lanes reversed");
  a_disp_enable: assert property (
    cap |=> {cfg.disp_b_en, cfg.disp_c_en} ==
    $past({display_b_ctrl_data_strap_i, display_c_ctrl_data_strap_i}))
    else $error("display enable wrong");
  a_cfg_hold: assert property (!$past(cap) |-> $stable(cfg))
    else $error("configuration changed without capture");
  a_grants_driven: assert property (
    $past(pins_functional) |->
    &{bus_grant0_n_oe, bus_grant1_n_oe, bus_grant2_n_oe, bus_grant3_n_oe})
    else $error("grant pins not driven in run");
endmodule
bind reset_strap_sampler reset_strap_sampler_chk
  #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) chk (
  .clk, .rst, .power_good, .audio_frame_sync_strap_i,
  .audio_serial_out_strap_i,
  .graphics_lane_reverse_n, .display_b_ctrl_data_strap_i,
  .display_c_ctrl_data_strap_i, .audio_frame_sync_strap_oe,
  .audio_serial_out_strap_oe, .card_slot_reset_n_oe, .beeper_out_oe,
  .display_b_ctrl_data_strap_oe, .display_c_ctrl_data_strap_oe,
  .bus_grant0_n_oe, .bus_grant1_n_oe, .bus_grant2_n_oe, .bus_grant3_n_oe,
  .cfg, .cfg_valid, .pins_functional);

//--- test/reset_strap_sampler_bench.sv
// self-checking bench of the strap sampler with a board model
`timescale 1ns/100ps
`include "strap_sampler_regs.svh"
module reset_strap_sampler_bench;
  typedef struct packed {logic [31:0] val; logic [31:0] msk;} note_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic power_good = 1'h0; // low holds the system in reset
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'h0;
  logic reg_re = 1'h0;
  logic re_d = 1'h0; // read answer due this cycle
  logic [5:0] func = 6'h00; // run-time levels and open-drain pulls
  logic [4:0] fit = 5'h00; // board resistors
  logic [3:0] g; // grants written
  strap_sampler_pkg::strap_cfg_t e; // expected configuration
  wire strap_sampler_pkg::strap_cfg_t cfg;
  wire [9:0] po;
  wire [9:0] poe;
  wire [9:0] pi;
  wire [1:0] disp_lvl; // registered display data levels, c then b
  wire [31:0] reg_rdata;
  wire lane_n;
  wire cfg_valid;
  wire pins_functional;
  note_t notes[$]; // expected read answers, oldest first
  note_t cur;
  int err_total = 0;
  int tests_run = 0;
  int seed = 32'h5BEC;
  always #10 clk = ~clk;
  reset_strap_sampler #(.ADDR_W(4), .CNT_W(8)) uut (
    .clk, .rst, .power_good, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .graphics_lane_reverse_n(lane_n), .cfg, .cfg_valid,
    .pins_functional, .disp_b_level(disp_lvl[0]), .disp_c_level(disp_lvl[1]),
    .audio_frame_sync_strap_i(pi[0]), .audio_frame_sync_strap_o(po[0]),
    .audio_frame_sync_strap_oe(poe[0]), .audio_serial_out_strap_i(pi[1]),
    .audio_serial_out_strap_o(po[1]), .audio_serial_out_strap_oe(poe[1]),
    .card_slot_reset_n_i(pi[2]), .card_slot_reset_n_o(po[2]),
    .card_slot_reset_n_oe(poe[2]), .beeper_out_i(pi[3]),
    .beeper_out_o(po[3]), .beeper_out_oe(poe[3]),
    .display_b_ctrl_data_strap_i(pi[4]), .display_b_ctrl_data_strap_o(po[4]),
    .display_b_ctrl_data_strap_oe(poe[4]),
    .display_c_ctrl_data_strap_i(pi[5]), .display_c_ctrl_data_strap_o(po[5]),
    .display_c_ctrl_data_strap_oe(poe[5]),
    .bus_grant0_n_i(pi[6]), .bus_grant0_n_o(po[6]), .bus_grant0_n_oe(poe[6]),
    .bus_grant1_n_i(pi[7]), .bus_grant1_n_o(po[7]), .bus_grant1_n_oe(poe[7]),
    .bus_grant2_n_i(pi[8]), .bus_grant2_n_o(po[8]), .bus_grant2_n_oe(poe[8]),
    .bus_grant3_n_i(pi[9]), .bus_grant3_n_o(po[9]), .bus_grant3_n_oe(poe[9]),
    .func_frame_sync(func[0]), .func_serial_out(func[1]),
    .func_card_reset_n(func[2]), .func_beeper(func[3]),
    .disp_b_pull_low(func[4]), .disp_c_pull_low(func[5]));
  strap_board board (.pin_o(po), .pin_oe(poe), .fit(fit), .pin_i(pi),
    .lane_n(lane_n));
  // one comparison, counted; four-state so an unknown never matches
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'h0;
  endtask
  // one-cycle read strobe; the answer is judged by the monitor
  task automatic rd(input logic [3:0] a, input logic [31:0] v, m);
    @(posedge clk);
    reg_re <= 1'h1;
    reg_addr <= a;
    notes.push_back('{val: v, msk: m});
    @(posedge clk);
    reg_re <= 1'h0;
  endtask
  // bounded wait for the run phase; a miss ends the run
  task automatic wait_run;
    for (int k = 0; k < 10 && pins_functional !== 1'h1; k++)
      @(posedge clk);
    check(32'(pins_functional), 32'h1);
    if (pins_functional !== 1'h1)
      tally_and_finish();
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (re_d && notes.size() > 0)
    begin
      cur = notes.pop_front();
      check(reg_rdata & cur.msk, cur.val);
    end
    re_d <= reg_re;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    // every strap combination, then noise on the pins while running
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk);
      power_good <= 1'h0;
      fit <= i[4:0];
      func <= $random(seed);
      repeat (4) @(posedge clk);
      power_good <= 1'h1;
      e = '0;
      e.ch03_width = strap_sampler_pkg::link_width_t'(i[0] & i[1]);
      e.gfx_lane_rev = i[4];
      e.disp_b_en = i[2];
      e.disp_c_en = i[3];
      wait_run();
      wr(`STRAP_ADDR_STATUS, $random(seed));
      rd(`STRAP_ADDR_STATUS, {26'h0, 2'h3, i[3], i[2], i[4], i[0] & i[1]},
        32'hFFFFE0FF);
      g = $random(seed);
      wr(`STRAP_ADDR_GRANT, {28'h0, g});
      repeat (2) @(posedge clk);
      #1;
      check({po[9:6], poe[9:6]}, {~g, 4'hF});
      // run-time levels reach the pins; open drain only pulls low
      check({po[5:0], poe[5:0], disp_lvl}, {2'h0, func[3:0], func[5:4],
        4'hF, ~func[5] & i[3], ~func[4] & i[2]});
      fit <= $random(seed);
      func <= $random(seed);
      repeat (3) @(posedge clk);
      #1;
      check(cfg, e);
      rd(`STRAP_ADDR_COUNT, i + 1, 32'hFF);
      $display("strap set %0d done", i);
    end
    // a one-cycle power good pulse captures but never runs
    @(posedge clk);
    power_good <= 1'h0;
    fit <= 5'h03;
    repeat (4) @(posedge clk);
    power_good <= 1'h1;
    @(posedge clk);
    power_good <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    check({pins_functional, poe, cfg}, {11'h0, 6'h20});
    rd(`STRAP_ADDR_COUNT, 32'h21, 32'hFF);
    $display("power good pulse done");
    rd(4'hF, 32'h0, 32'hFFFFFFFF);
    // second reset, with power good low, clears the captured state
    @(posedge clk);
    rst <= 1'h1;
    power_good <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    check({cfg_valid, pins_functional, poe, po, cfg}, 32'h0);
    // release on a rising edge, like every other input
    @(posedge clk);
    rst <= 1'h0;
    rd(`STRAP_ADDR_COUNT, 32'h0, 32'hFF);
    repeat (3) @(posedge clk);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
